// ==== pkg/sec_pkg.sv ====
// Constants and types for the status event counter block
package sec_pkg;

    // Register byte offsets
    localparam logic [11:0] SEC_OFF_SEL_A = 12'h0E4;
    localparam logic [11:0] SEC_OFF_SEL_B = 12'h0E8;
    localparam logic [11:0] SEC_OFF_THR_A = 12'h0EC;
    localparam logic [11:0] SEC_OFF_THR_B = 12'h0F0;
    localparam logic [11:0] SEC_OFF_CNT_A = 12'h118;
    localparam logic [11:0] SEC_OFF_CNT_B = 12'h11C;
    localparam logic [11:0] SEC_OFF_STAT = 12'h120;

    // Counter set layout
    localparam int SEC_NUM_CNT = 6;
    localparam int SEC_PER_REG = 3;
    localparam int SEC_WIDE_W = 12;
    localparam int SEC_NARROW_W = 10;
    localparam int SEC_CNT_LSB_MID = 12;
    localparam int SEC_CNT_LSB_TOP = 22;

    // Select register lane layout
    localparam int SEC_LANE_W = 8;
    localparam int SEC_SRC_LSB = 2;
    localparam int SEC_SRC_W = 6;
    localparam int SEC_ON_BIT = 1;
    localparam int SEC_WIPE_BIT = 0;
    localparam int SEC_NUM_SRC = 64;

    // Source codes fed back from the counters themselves, and one reserved code
    localparam int SEC_SRC_OVF_GRP = 'h1D;
    localparam int SEC_SRC_OVF_3 = 'h1E;
    localparam int SEC_SRC_OVF_0 = 'h1F;
    localparam int SEC_SRC_RSVD = 'h39;
    localparam int SEC_SRC_OVF_5 = 'h3C;
    localparam int SEC_SRC_OVF_4 = 'h3D;
    localparam int SEC_SRC_OVF_2 = 'h3E;
    localparam int SEC_SRC_OVF_1 = 'h3F;

    // Reset values
    localparam logic [SEC_SRC_W-1:0] SEC_SRC_RST = 6'h00;
    localparam logic [SEC_WIDE_W-1:0] SEC_THR_RST = 12'h000;

    typedef struct packed {
        logic [SEC_SRC_W-1:0] source_code;
        logic on;
    } sec_sel_t;

    localparam sec_sel_t SEC_SEL_RST = '{source_code: SEC_SRC_RST, on: 1'b0};

    function automatic int sec_cnt_width(input int k);
        return ((k % SEC_PER_REG) == 0) ? SEC_WIDE_W : SEC_NARROW_W;
    endfunction

    function automatic int sec_cnt_lsb(input int k);
        return ((k % SEC_PER_REG) == 0) ? 0 :
               ((k % SEC_PER_REG) == 1) ? SEC_CNT_LSB_MID : SEC_CNT_LSB_TOP;
    endfunction

endpackage

// ==== design/sec_status_event_counters.sv ====
// Six status event counters with Avalon-MM register access
//
// Function
// - Counter five reads in bits 31:22 of register 0x11C.
// - Counter four reads in bits 21:12 of register 0x11C.
// - Counter three, twelve bits, reads in bits 11:0 of 0x11C.
// - Register 0xE4 bits 23:18 hold counter two source; 31:24 reserved.
// - A counter counts only while its enable bit is set.
// - Writing one to a clear bit zeroes that counter.
// - Counter one: source 15:10, enable 9, clear 8 in 0xE4.
// - Counter zero: source 7:2, enable 1, clear 0 in 0xE4.
// - Register 0xE8 holds counter five source, enable, clear at 23:16.
// - Counters four and three use the lower lanes of 0xE8.
// - Codes 00 and 01 count parity and access errors.
// - Code 02 counts each clock with realtime parity fault.
// - Codes 03 to 0A count sequencer task events, task 1 first.
// - Codes 0B, 0C, 0E count busy durations per clock.
// - Code 0D counts port events, 0F counts I2C errors.
// - Codes 10 to 16 count audio and video DMA or FIFO faults.
// - Codes 17 and 18 count chosen fields on video ports.
// - Codes 19 to 1C count active edges on pins 3 to 0.
// - Codes 1D, 1E, 1F count this block's threshold overflows.
// - Codes 20 and 21 count request-to-grant and master active clocks.
// - Codes 22 to 27 count sequencer access, page errors, busy clocks.
// - Codes 28 to 2A count port timeouts, format and address errors.
// - Passing the threshold wraps the counter to zero and flags status.
// - Register 0x118 holds counters two, one and zero.
// - Thresholds at 0xEC and 0xF0 mirror counter field layout.
// - Codes 2B to 3B count further events, 39 reserved; 3C to 3F count overflows of counters five, four, two, one.
`timescale 1ns/1ps
`default_nettype none

module sec_status_event_counters #(
    parameter int ADDR_W = 10
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [sec_pkg::SEC_NUM_SRC-1:0] i_status,
    output logic [sec_pkg::SEC_NUM_CNT-1:0] o_overflow
);
    import sec_pkg::*;

    if (ADDR_W < 9 || ADDR_W > 12) begin : g_bad_addr
        $error("ADDR_W must be 9 to 12");
    end

    // Reset release through two flip-flops
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rst_n = rst_sync_ff;

    // Bus handshake: one wait state on every access
    logic ack_ff;
    wire logic req = i_avs_read | i_avs_write;
    wire logic wr_acc = i_avs_write & ack_ff;
    wire logic rd_cap = i_avs_read & ~ack_ff;
    assign o_avs_waitrequest = req & ~ack_ff;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Address decode
    wire logic [11:0] addr = 12'(i_avs_address);
    wire logic hit_sel_a = (addr == SEC_OFF_SEL_A);
    wire logic hit_sel_b = (addr == SEC_OFF_SEL_B);
    wire logic hit_thr_a = (addr == SEC_OFF_THR_A);
    wire logic hit_thr_b = (addr == SEC_OFF_THR_B);
    wire logic hit_cnt_a = (addr == SEC_OFF_CNT_A);
    wire logic hit_cnt_b = (addr == SEC_OFF_CNT_B);
    wire logic hit_stat = (addr == SEC_OFF_STAT);
    wire logic [1:0] hit_sel = {hit_sel_b, hit_sel_a};
    wire logic [1:0] hit_thr = {hit_thr_b, hit_thr_a};

    wire logic [31:0] be_mask = {{8{i_avs_byteenable[3]}},
                                 {8{i_avs_byteenable[2]}},
                                 {8{i_avs_byteenable[1]}},
                                 {8{i_avs_byteenable[0]}}};

    // Register views, assembled per counter below
    wire logic [31:0] sel_word [2];
    wire logic [31:0] thr_word [2];
    wire logic [31:0] cnt_word [2];
    wire logic [31:0] thr_merge [2];
    wire logic [SEC_NUM_SRC-1:0] src_vec;
    wire logic [SEC_NUM_CNT-1:0] over;
    logic [SEC_NUM_CNT-1:0] ovf_ff;
    logic [SEC_NUM_CNT-1:0] stat_ff;

    assign sel_word[0][31:24] = 8'h00;
    assign sel_word[1][31:24] = 8'h00;

    assign thr_merge[0] = (thr_word[0] & ~be_mask) |
                          (i_avs_writedata & be_mask);
    assign thr_merge[1] = (thr_word[1] & ~be_mask) |
                          (i_avs_writedata & be_mask);

    wire logic [SEC_NUM_SRC-1:0] fb_mask =
        (64'h1 << SEC_SRC_OVF_GRP) | (64'h1 << SEC_SRC_OVF_3) |
        (64'h1 << SEC_SRC_OVF_0) | (64'h1 << SEC_SRC_OVF_5) |
        (64'h1 << SEC_SRC_OVF_4) | (64'h1 << SEC_SRC_OVF_2) |
        (64'h1 << SEC_SRC_OVF_1) | (64'h1 << SEC_SRC_RSVD);
    wire logic ovf_grp = ovf_ff[1] | ovf_ff[2] | ovf_ff[4] | ovf_ff[5];
    wire logic [SEC_NUM_SRC-1:0] fb_taps =
        ({63'h0, ovf_grp} << SEC_SRC_OVF_GRP) |
        ({63'h0, ovf_ff[3]} << SEC_SRC_OVF_3) |
        ({63'h0, ovf_ff[0]} << SEC_SRC_OVF_0) |
        ({63'h0, ovf_ff[5]} << SEC_SRC_OVF_5) |
        ({63'h0, ovf_ff[4]} << SEC_SRC_OVF_4) |
        ({63'h0, ovf_ff[2]} << SEC_SRC_OVF_2) |
        ({63'h0, ovf_ff[1]} << SEC_SRC_OVF_1);
    assign src_vec = (i_status & ~fb_mask) | fb_taps;

    for (genvar k = 0; k < SEC_NUM_CNT; k++) begin : g_cnt
        localparam int W = sec_cnt_width(k);
        localparam int LSB = sec_cnt_lsb(k);
        localparam int LANE = (k % SEC_PER_REG) * SEC_LANE_W;
        localparam int R = k / SEC_PER_REG;
        localparam int BYTE = k % SEC_PER_REG;

        sec_sel_t sel_ff;
        logic [W-1:0] thr_ff;
        logic [W-1:0] cnt_ff;

        wire logic lane_wr = wr_acc & hit_sel[R] & i_avs_byteenable[BYTE];
        wire logic thr_wr = wr_acc & hit_thr[R];
        // Lane fields of the select word
        // Lane fields of the select word
        // Lane fields of the select word
        wire sec_sel_t nxt_sel = lane_wr ?
            i_avs_writedata[LANE+SEC_ON_BIT +: SEC_SRC_W+1] : sel_ff;
        wire logic wipe = lane_wr & i_avs_writedata[LANE+SEC_WIPE_BIT];
        wire logic [W-1:0] nxt_thr = thr_wr ? thr_merge[R][LSB +: W] : thr_ff;

        // One count per selected level clock
        // One count per selected level clock
        wire logic hit = sel_ff.on & src_vec[sel_ff.source_code];
        assign over[k] = hit & (cnt_ff >= thr_ff) & ~wipe;
        // At most one count per clock
        wire logic [W-1:0] nxt_cnt = wipe ? '0 :
                                     over[k] ? '0 :
                                     hit ? W'(cnt_ff + 1'b1) : cnt_ff;

        assign sel_word[R][LANE +: SEC_LANE_W] = {sel_ff, 1'b0};
        assign thr_word[R][LSB +: W] = thr_ff;
        assign cnt_word[R][LSB +: W] = cnt_ff;

        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                sel_ff <= SEC_SEL_RST;
                thr_ff <= W'(SEC_THR_RST);
                cnt_ff <= '0;
            end else begin
                sel_ff <= nxt_sel;
                thr_ff <= nxt_thr;
                cnt_ff <= nxt_cnt;
            end
        end
    end

    // Sticky status, set wins over clear
    wire logic [SEC_NUM_CNT-1:0] stat_clr =
        (wr_acc & hit_stat & i_avs_byteenable[0]) ?
        i_avs_writedata[SEC_NUM_CNT-1:0] : '0;
    wire logic [SEC_NUM_CNT-1:0] nxt_stat = (stat_ff & ~stat_clr) | over;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ovf_ff <= '0;
            stat_ff <= '0;
        end else begin
            ovf_ff <= over;
            stat_ff <= nxt_stat;
        end
    end
    assign o_overflow = ovf_ff;

    // Read data, unmapped addresses read zero
    logic [31:0] rdata_ff;
    wire logic [31:0] rd_word =
        hit_sel_a ? sel_word[0] :
        hit_sel_b ? sel_word[1] :
        hit_thr_a ? thr_word[0] :
        hit_thr_b ? thr_word[1] :
        hit_cnt_a ? cnt_word[0] :
        hit_cnt_b ? cnt_word[1] :
        hit_stat ? {{(32-SEC_NUM_CNT){1'b0}}, stat_ff} : 32'h0000_0000;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_cap) begin
            rdata_ff <= rd_word;
        end
    end
    assign o_avs_readdata = rdata_ff;

endmodule // sec_status_event_counters

`default_nettype wire

// ==== tb/sec_counters_properties.sv ====
// Checker for select register readback, handshake and overflow of the counters
`timescale 1ns/1ps
`default_nettype none
module sec_counters_properties
    import sec_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [sec_pkg::SEC_NUM_CNT-1:0] o_overflow
);
    localparam logic [31:0] SEL_MASK = 32'h00FE_FEFE;
    logic [31:0] mir_a_ff;
    logic [31:0] mir_b_ff;
    wire logic req = i_avs_read || i_avs_write;
    wire logic wr_done = i_avs_write && !o_avs_waitrequest;
    wire logic rd_done = i_avs_read && !o_avs_waitrequest;
    wire logic sel_a = i_avs_address == SEC_OFF_SEL_A[ADDR_W-1:0];
    wire logic sel_b = i_avs_address == SEC_OFF_SEL_B[ADDR_W-1:0];
    wire logic [5:0] on_now = {mir_b_ff[17], mir_b_ff[9], mir_b_ff[1],
                               mir_a_ff[17], mir_a_ff[9], mir_a_ff[1]};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Shadow of the select registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mir_a_ff <= '0;
            mir_b_ff <= '0;
        end else begin
            for (int j = 0; j < 4; j++) begin
                if (wr_done && sel_a && i_avs_byteenable[j]) begin
                    mir_a_ff[8*j +: 8] <= i_avs_writedata[8*j +: 8];
                end
                if (wr_done && sel_b && i_avs_byteenable[j]) begin
                    mir_b_ff[8*j +: 8] <= i_avs_writedata[8*j +: 8];
                end
            end
        end
    end
    property p_sel_a;
        rd_done && sel_a |-> o_avs_readdata == (mir_a_ff & SEL_MASK);
    endproperty
    a_sel_a: assert property (p_sel_a)
        else $error("select A readback wrong");
    property p_sel_b;
        rd_done && sel_b |-> o_avs_readdata == (mir_b_ff & SEL_MASK);
    endproperty
    a_sel_b: assert property (p_sel_b)
        else $error("select B readback wrong");
    property p_rsv;
        rd_done && (sel_a || sel_b) |-> o_avs_readdata[31:24] == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved select bits not zero");
    property p_wipe;
        rd_done && (sel_a || sel_b) |-> !(o_avs_readdata[16] ||
            o_avs_readdata[8] || o_avs_readdata[0]);
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("clear bit reads back one");
    property p_ovf_on;
        (o_overflow & ~($past(on_now, 1) | $past(on_now, 2))) == '0;
    endproperty
    a_ovf_on: assert property (p_ovf_on)
        else $error("overflow from a disabled counter");
    property p_wait_one;
        req && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("access not answered after one wait");
    property p_wait_idle;
        !req |-> !o_avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("wait raised without a request");
    property p_wait_first;
        $rose(req) |-> o_avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("first request cycle not held off");
endmodule // sec_counters_properties
bind sec_status_event_counters sec_counters_properties #(.ADDR_W(ADDR_W))
    u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_overflow(o_overflow));
`default_nettype wire

// ==== tb/sec_status_event_counters_tb.sv ====
// Testbench for the status event counter block
`timescale 1ns/1ps
`default_nettype none
module sec_status_event_counters_tb;
    import sec_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be = '0;
    logic [31:0] rdata;
    logic wreq;
    logic [63:0] st = '0;
    logic [5:0] ovf;
    logic [31:0] d;
    logic [11:0] regs [7] = '{SEC_OFF_SEL_A, SEC_OFF_SEL_B, SEC_OFF_THR_A,
        SEC_OFF_THR_B, SEC_OFF_CNT_A, SEC_OFF_CNT_B, 12'h3FC};
    int fails = 0;
    int check_count = 0;
    int ovf_seen = 0;
    int k;
    int n;
    always #10 clock = ~clock;
    always @(posedge clock) if (ovf[3] === 1'b1) ovf_seen++;
    sec_status_event_counters #(.ADDR_W(10)) dut (.i_clock(clock),
        .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_status(st),
        .o_overflow(ovf));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] v, input logic [3:0] b);
        addr <= a[9:0];
        wdata <= v;
        be <= b;
        wr <= w;
        rd <= !w;
        do @(posedge clock); while (wreq !== 1'b0);
        d = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic sel(input int c, input logic [5:0] s, input logic [1:0] f);
        acc(1'b1, (c < 3) ? SEC_OFF_SEL_A : SEC_OFF_SEL_B,
            {24'h0, s, f} << (8 * (c % 3)), 4'h1 << (c % 3));
    endtask
    task automatic pulse(input int c, input int m);
        st[c] <= 1'b1;
        st[c+1] <= 1'b1;
        repeat (m) @(posedge clock);
        st[c] <= 1'b0;
        repeat (2) @(posedge clock);
        st[c+1] <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_cnt(input int c);
        acc(1'b0, (c < 3) ? SEC_OFF_CNT_A : SEC_OFF_CNT_B, '0, 4'hF);
        d = (d >> ((c % 3 == 0) ? 0 : (c % 3 == 1) ? 12 : 22)) &
            ((c % 3 == 0) ? 32'hFFF : 32'h3FF);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (regs[i]) begin
            acc(1'b0, regs[i], '0, 4'hF);
            chk("reset_value", 32'h0, d);
        end
        $display("test reset_values done");
        acc(1'b1, SEC_OFF_SEL_A, 32'hFFFF_FFFF, 4'hF);
        acc(1'b1, SEC_OFF_SEL_A, 32'h0, 4'h2);
        acc(1'b0, SEC_OFF_SEL_A, '0, 4'hF);
        chk("select_a", 32'h00FE_00FE, d);
        acc(1'b1, SEC_OFF_SEL_B, 32'hA5A5_A5A5, 4'hF);
        acc(1'b0, SEC_OFF_SEL_B, '0, 4'hF);
        chk("select_b", 32'h00A4_A4A4, d);
        acc(1'b1, SEC_OFF_THR_A, 32'hFFFF_FFFF, 4'hF);
        acc(1'b1, SEC_OFF_THR_B, 32'hFFFF_FFFF, 4'hF);
        acc(1'b0, SEC_OFF_THR_A, '0, 4'hF);
        chk("threshold", 32'hFFFF_FFFF, d);
        acc(1'b1, SEC_OFF_SEL_A, 32'h0, 4'hF);
        acc(1'b1, SEC_OFF_SEL_B, 32'h0, 4'hF);
        $display("test field_layout done");
        for (int c = 0; c <= 'h2A; c++) begin
            k = c % 6;
            n = c % 5 + 1;
            if (c >= 'h1D && c <= 'h1F) continue;
            sel(k, c[5:0], 2'b11);
            pulse(c, n);
            rd_cnt(k);
            chk("count", n, d);
            sel(k, c[5:0], 2'b00);
            pulse(c, 2);
            rd_cnt(k);
            chk("held", n, d);
        end
        $display("test source_sweep done");
        acc(1'b1, SEC_OFF_THR_B, 32'hFFFF_F002, 4'hF);
        sel(0, 6'h1E, 2'b11);
        sel(3, 6'h00, 2'b11);
        pulse(0, 6);
        repeat (3) @(posedge clock);
        rd_cnt(3);
        chk("wrap_count", 32'h0, d);
        rd_cnt(0);
        chk("wrap_feedback", 32'h2, d);
        chk("wrap_pulses", 32'h2, ovf_seen);
        acc(1'b0, SEC_OFF_STAT, '0, 4'hF);
        chk("status", 32'h8, d);
        acc(1'b1, SEC_OFF_STAT, 32'h3F, 4'h1);
        acc(1'b0, SEC_OFF_STAT, '0, 4'hF);
        chk("status_clear", 32'h0, d);
        $display("test wrap done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        finish_test();
    end
endmodule // sec_status_event_counters_tb
`default_nettype wire
